// file: hw/system_clock_pwm.sv
// timer driven pwm that makes the converter system clock
`timescale 1ns/1ns
module system_clock_pwm (
   // clock, reset, sleep freeze
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   // system clock pin
   output logic clock_out_pin,
   // sync clock pin, two-way
   input wire logic sync_clock_pin_in,
   output logic sync_clock_pin_out,
   output logic sync_clock_pin_oe_n
);
   // ************************************************************
   // state and bus decode
   // ************************************************************
   pwm_clk_pkg::pwm_state_t s, n;
   logic req;
   logic wr;
   logic hit_ctrl;
   logic hit_period;
   logic hit_count;
   logic hit_mode;
   logic hit_duty;
   logic hit_phase;
   logic hit_status;
   logic tick;
   logic wrap;
   logic sync_level;
   logic sync_rise;
   logic is_secondary;
   logic load_pulse;

   // one-cycle registered ack; a new request only after ack falls
   assign req = wb_cyc_i && wb_stb_i && !s.ack;
   assign wr = req && wb_we_i && wb_sel_i[0];
   assign hit_ctrl = wr && (wb_adr_i == pwm_clk_pkg::OFF_TIMER_CONTROL);
   assign hit_period = wr && (wb_adr_i == pwm_clk_pkg::OFF_PERIOD_LIMIT);
   assign hit_count = wr && (wb_adr_i == pwm_clk_pkg::OFF_TICK_COUNT);
   assign hit_mode = wr && (wb_adr_i == pwm_clk_pkg::OFF_SYNC_MODE);
   assign hit_duty = wr && (wb_adr_i == pwm_clk_pkg::OFF_DUTY_STAGING);
   assign hit_phase = wr && (wb_adr_i == pwm_clk_pkg::OFF_PHASE_STAGING);
   assign hit_status = wr && (wb_adr_i == pwm_clk_pkg::OFF_STATUS);

   // ************************************************************
   // leaf blocks
   // ************************************************************
   tick_prescaler tick_prescaler_inst (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .en(s.run),
      .clear(hit_ctrl || hit_count),
      .div_sel(s.div_sel),
      .tick(tick)
   );

   sync_pin_filter sync_pin_filter_inst (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .pin_in(sync_clock_pin_in),
      .level(sync_level),
      .rise(sync_rise)
   );

   // ************************************************************
   // timer, duty and phase
   // ************************************************************
   // no capture or compare path: the match only feeds the pwm and the status flag
   // tick is only ever high while run is set
   assign wrap = tick && (s.count == s.period);
   assign is_secondary = (s.mode == pwm_clk_pkg::MODE_SECONDARY);
   // received main clock OR own period match
   assign load_pulse = is_secondary && (sync_rise || wrap);

   always_comb begin
      n = s;
      n.ack = req;
      // timer increment; wrap clears the count on that same tick
      if (tick) begin
         n.count = wrap ? 8'h00 : s.count + 8'h01;
      end
      if (wrap) begin
         n.duty_act = s.duty_stg;
      end
      if (load_pulse) begin
         n.duty_act = s.duty_stg;
         n.phase_act = s.phase_stg;
      end
      // secondary restarts its period phase plus one ticks after the main edge
      if (is_secondary && sync_rise) begin
         n.phase_wait = s.phase_stg;
         n.phase_pend = 1'b1;
      end else if (s.phase_pend && tick) begin
         if (s.phase_wait == 8'h00) begin
            n.count = 8'h00;
            n.phase_pend = 1'b0;
         end else begin
            n.phase_wait = s.phase_wait - 8'h01;
         end
      end
      if (!is_secondary) begin
         n.phase_pend = 1'b0;
      end
      // software writes; a match in the same cycle still sets the flag
      if (hit_ctrl) begin
         n.run = wb_dat_i[pwm_clk_pkg::RUN_BIT];
         n.div_sel = wb_dat_i[pwm_clk_pkg::DIV_LSB +: 2];
      end
      if (hit_period) begin
         n.period = wb_dat_i[7:0];
      end
      if (hit_count) begin
         n.count = wb_dat_i[7:0];
      end
      if (hit_mode) begin
         n.mode = pwm_clk_pkg::mode_t'(wb_dat_i[pwm_clk_pkg::MODE_LSB +: 2]);
      end
      if (hit_duty) begin
         n.duty_stg = wb_dat_i[7:0];
      end
      if (hit_phase) begin
         n.phase_stg = wb_dat_i[7:0];
      end
      if (hit_status && wb_dat_i[pwm_clk_pkg::FLAG_BIT]) begin
         n.flag = 1'b0;
      end
      if (wrap) begin
         n.flag = 1'b1;
      end
      // fixed duty compare: high from count 0 until count reaches duty
      // duty is never touched here beyond the reload, the analog loop trims on-time
      n.clk_out = n.run && (n.count < n.duty_act);
      case (n.mode)
         pwm_clk_pkg::MODE_MAIN: begin
            n.sync_out = n.clk_out;
            n.sync_oe_n = 1'b0;
         end
         pwm_clk_pkg::MODE_SECONDARY: begin
            n.sync_out = 1'b0;
            n.sync_oe_n = 1'b1;
         end
         default: begin
            n.sync_out = 1'b0;
            n.sync_oe_n = 1'b1;
         end
      endcase
      // read mux, unmapped offsets read zero
      n.rdat = 32'h0000_0000;
      if (req && !wb_we_i) begin
         case (wb_adr_i)
            pwm_clk_pkg::OFF_TIMER_CONTROL: begin
               n.rdat[pwm_clk_pkg::RUN_BIT] = s.run;
               n.rdat[pwm_clk_pkg::DIV_LSB +: 2] = s.div_sel;
            end
            pwm_clk_pkg::OFF_PERIOD_LIMIT: begin
               n.rdat[7:0] = s.period;
            end
            pwm_clk_pkg::OFF_TICK_COUNT: begin
               n.rdat[7:0] = s.count;
            end
            pwm_clk_pkg::OFF_SYNC_MODE: begin
               n.rdat[pwm_clk_pkg::MODE_LSB +: 2] = s.mode;
            end
            pwm_clk_pkg::OFF_DUTY_STAGING: begin
               n.rdat[7:0] = s.duty_stg;
            end
            pwm_clk_pkg::OFF_PHASE_STAGING: begin
               n.rdat[7:0] = s.phase_stg;
            end
            pwm_clk_pkg::OFF_STATUS: begin
               n.rdat[pwm_clk_pkg::FLAG_BIT] = s.flag;
               n.rdat[pwm_clk_pkg::STAT_DUTY_LSB +: 8] = s.duty_act;
               n.rdat[pwm_clk_pkg::STAT_PHASE_LSB +: 8] = s.phase_act;
            end
            default: begin
               n.rdat = 32'h0000_0000;
            end
         endcase
      end
   end

   // ce low is sleep: everything, pins included, holds its value
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
         s.period <= pwm_clk_pkg::PERIOD_RST;
         s.count <= pwm_clk_pkg::COUNT_RST;
         s.sync_oe_n <= 1'b1;
      end else if (ce) begin
         s <= n;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign wb_ack_o = s.ack;
   assign wb_dat_o = s.rdat;
   assign clock_out_pin = s.clk_out;
   assign sync_clock_pin_out = s.sync_out;
   assign sync_clock_pin_oe_n = s.sync_oe_n;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   sequence wrap_seen;
      ce && wrap && !hit_count && !hit_duty;
   endsequence

   sequence main_edge_seen;
      ce && is_secondary && sync_rise && !hit_duty && !hit_phase;
   endsequence

   a_wrap_clears_count: assert property (
      wrap_seen |=> (s.count == 8'h00) && (s.duty_act == $past(s.duty_stg)))
      else $error("period match did not clear count and load duty");

   a_match_sets_flag: assert property (
      (ce && wrap) |=> s.flag)
      else $error("period match flag not set");

   a_stopped_holds: assert property (
      (ce && !s.run && !hit_count && !(is_secondary && s.phase_pend)) |=> $stable(s.count))
      else $error("timer moved while stopped");

   a_ctrl_clears_div: assert property (
      (ce && hit_ctrl && wb_dat_i[pwm_clk_pkg::DIV_LSB +: 2] != 2'b00) |=> !tick)
      else $error("prescaler not cleared by control write");

   a_sleep_freeze: assert property (
      !ce |=> $stable(s.count) && $stable(clock_out_pin) && $stable(sync_clock_pin_out))
      else $error("state moved during sleep");

   a_zero_duty_low: assert property (
      (s.duty_act == 8'h00) |-> !clock_out_pin)
      else $error("clock high with zero duty");

   a_main_drives_pin: assert property (
      (s.mode == pwm_clk_pkg::MODE_MAIN) |-> !sync_clock_pin_oe_n
         && (sync_clock_pin_out == clock_out_pin))
      else $error("main unit not driving sync pin");

   a_alone_quiet: assert property (
      (s.mode == pwm_clk_pkg::MODE_ALONE) |-> sync_clock_pin_oe_n)
      else $error("stand-alone unit drives sync pin");

   a_secondary_loads: assert property (
      main_edge_seen |=> (s.duty_act == $past(s.duty_stg))
         && (s.phase_act == $past(s.phase_stg)) && s.phase_pend)
      else $error("main edge did not load duty and phase");

   a_div_spacing: assert property (
      (ce && tick && s.div_sel == 2'b01 && !hit_ctrl && !hit_count)
         ##1 (ce && !hit_ctrl && !hit_count) [*4] |-> tick)
      else $error("divide-by-4 tick spacing wrong");

   sequence phase_due;
      ce && is_secondary && s.phase_pend && tick && (s.phase_wait == 8'h00) && !sync_rise
         && !hit_count;
   endsequence

   a_phase_restart: assert property (
      phase_due |=> (s.count == 8'h00) && !s.phase_pend)
      else $error("phase wait did not restart the count");

   a_count_steps: assert property (
      (ce && tick && !wrap && !hit_count && !s.phase_pend)
         |=> (s.count == $past(s.count) + 8'h01))
      else $error("timer did not step by one");

   a_high_at_start: assert property (
      (ce && wrap && (s.duty_stg != 8'h00) && !hit_ctrl && !hit_count)
         |=> clock_out_pin)
      else $error("clock not high at period start");

   a_duty_low_at: assert property (
      (s.count >= s.duty_act) |-> !clock_out_pin)
      else $error("clock high past duty");

   a_run_low_out: assert property (
      !s.run |-> !clock_out_pin)
      else $error("clock high while timer stopped");

   a_duty_hold_mid: assert property (
      (ce && !wrap && !load_pulse) |=> $stable(s.duty_act))
      else $error("active duty changed between matches");

   a_duty_stg_writes: assert property (
      (ce && !hit_duty) |=> $stable(s.duty_stg))
      else $error("staged duty changed without a write");

   a_flag_holds: assert property (
      (ce && s.flag && !hit_status) |=> s.flag)
      else $error("match flag dropped without a clear");

   a_secondary_released: assert property (
      (s.mode == pwm_clk_pkg::MODE_SECONDARY) |-> sync_clock_pin_oe_n)
      else $error("secondary unit drives sync pin");

   a_ack_one_cycle: assert property (
      (ce && wb_ack_o) |=> !wb_ack_o)
      else $error("bus ack held longer than one cycle");

   a_rdat_zero_idle: assert property (
      !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
      else $error("read data not zero outside ack");
endmodule

// file: shared/pwm_clk_pkg.sv
// constants, types and helpers shared by the system-clock pwm block
package pwm_clk_pkg;

   // ************************************************************
   // register byte offsets (word aligned)
   // ************************************************************
   localparam logic [7:0] OFF_TIMER_CONTROL = 8'h00;
   localparam logic [7:0] OFF_PERIOD_LIMIT = 8'h04;
   localparam logic [7:0] OFF_TICK_COUNT = 8'h08;
   localparam logic [7:0] OFF_SYNC_MODE = 8'h0c;
   localparam logic [7:0] OFF_DUTY_STAGING = 8'h10;
   localparam logic [7:0] OFF_PHASE_STAGING = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int RUN_BIT = 2;
   localparam int DIV_LSB = 0;
   localparam int MODE_LSB = 6;
   localparam int FLAG_BIT = 0;
   localparam int STAT_DUTY_LSB = 8;
   localparam int STAT_PHASE_LSB = 16;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [7:0] PERIOD_RST = 8'hff;
   localparam logic [7:0] COUNT_RST = 8'h00;

   // ************************************************************
   // prescaler terminal counts (divisor minus one)
   // ************************************************************
   localparam logic [3:0] LAST_DIV1 = 4'h0;
   localparam logic [3:0] LAST_DIV4 = 4'h3;
   localparam logic [3:0] LAST_DIV8 = 4'h7;
   localparam logic [3:0] LAST_DIV16 = 4'hf;

   // sync mode select, {hi, lo}
   typedef enum logic [1:0] {
      MODE_ALONE = 2'b00,
      MODE_ALONE_ALT = 2'b01,
      MODE_MAIN = 2'b10,
      MODE_SECONDARY = 2'b11
   } mode_t;

   typedef struct packed {
      logic run;
      logic [1:0] div_sel;
      logic [7:0] period;
      logic [7:0] count;
      mode_t mode;
      logic [7:0] duty_stg;
      logic [7:0] duty_act;
      logic [7:0] phase_stg;
      logic [7:0] phase_act;
      logic [7:0] phase_wait;
      logic phase_pend;
      logic flag;
      logic clk_out;
      logic sync_out;
      logic sync_oe_n;
      logic ack;
      logic [31:0] rdat;
   } pwm_state_t;

   typedef struct packed {
      logic [3:0] cnt;
   } presc_state_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } pin_state_t;

   function automatic logic [3:0] prescale_last(input logic [1:0] sel);
      case (sel)
         2'b00: prescale_last = LAST_DIV1;
         2'b01: prescale_last = LAST_DIV4;
         2'b10: prescale_last = LAST_DIV8;
         default: prescale_last = LAST_DIV16;
      endcase
   endfunction

endpackage

// file: hw/tick_prescaler.sv
// prescaler that turns the core clock into timer increment ticks
`timescale 1ns/1ns
module tick_prescaler (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // control
   input wire logic en,
   input wire logic clear,
   input wire logic [1:0] div_sel,
   // result
   output logic tick
);
   pwm_clk_pkg::presc_state_t s, n;
   logic [3:0] last;

   assign last = pwm_clk_pkg::prescale_last(div_sel);
   assign tick = en && !clear && (s.cnt == last);

   always_comb begin
      n = s;
      if (clear) begin
         n.cnt = 4'h0;
      end else if (en) begin
         n.cnt = (s.cnt >= last) ? 4'h0 : s.cnt + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else if (ce) begin
         s <= n;
      end
   end
endmodule

// file: hw/sync_pin_filter.sv
// three-stage synchroniser with agreement filter for the sync clock pin
`timescale 1ns/1ns
module sync_pin_filter (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // pin side
   input wire logic pin_in,
   // result
   output logic level,
   output logic rise
);
   pwm_clk_pkg::pin_state_t s, n;

   // s1 only feeds s2; the filter looks at s2 and s3
   assign level = s.level;
   assign rise = (s.s2 == s.s3) && s.s2 && !s.level;

   always_comb begin
      n = s;
      n.s1 = pin_in;
      n.s2 = s.s1;
      n.s3 = s.s2;
      if (s.s2 == s.s3) begin
         n.level = s.s2;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else if (ce) begin
         s <= n;
      end
   end
endmodule

// file: verif/sync_main_model.sv
// far-side main unit that supplies the sync clock on the shared pin
`timescale 1ns/1ns
module sync_main_model #(
   parameter int HALF = 20
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // bench control
   input wire logic en,
   // design side of the pin
   input wire logic dut_out,
   input wire logic dut_oe_n,
   // resolved pin level
   output logic line
);
   logic drv_r = 1'b0;
   logic last_r = 1'b0;
   int cnt_r = 0;
   // ************************************************************
   // main clock, free running while enabled
   // ************************************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         drv_r <= 1'b0;
         cnt_r <= 0;
      end else if (en) begin
         cnt_r <= (cnt_r == HALF - 1) ? 0 : cnt_r + 1;
         if (cnt_r == HALF - 1) begin
            drv_r <= !drv_r;
         end
      end
   end
   // no pull on the pin: a released line must not look stable
   always_ff @(posedge clk) begin
      last_r <= line;
   end
   always_comb begin
      if (!dut_oe_n) begin
         line = dut_out;
      end else if (en) begin
         line = drv_r;
      end else begin
         line = !last_r;
      end
   end
endmodule

// file: verif/system_clock_pwm_bench.sv
// self-checking bench for the system-clock pwm block
`timescale 1ns/1ns
module system_clock_pwm_bench;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic wb_ack_o;
   logic [31:0] wb_dat_o;
   logic clock_out_pin;
   logic pin_line;
   logic sync_out;
   logic sync_oe_n;
   logic model_en = 1'b0;
   int miscompares = 0;
   int n_tests = 0;

   always #2 clk = !clk;

   system_clock_pwm system_clock_pwm_inst (.clk(clk), .rstn(rstn), .ce(ce),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
      .clock_out_pin(clock_out_pin), .sync_clock_pin_in(pin_line),
      .sync_clock_pin_out(sync_out), .sync_clock_pin_oe_n(sync_oe_n));
   sync_main_model sync_main_model_inst (.clk(clk), .rstn(rstn), .en(model_en),
      .dut_out(sync_out), .dut_oe_n(sync_oe_n), .line(pin_line));

   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                      output logic [31:0] rd);
      int k;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_sel_i <= 4'hf;
      wb_adr_i <= adr;
      wb_dat_i <= {24'h0, wd};
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 100);
      if (k >= 100) miscompares++;
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      wb_sel_i <= 4'h0;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
      logic [31:0] junk;
      bus(1'b1, adr, wd, junk);
   endtask

   task automatic rd(input logic [7:0] adr, output logic [31:0] v);
      bus(1'b0, adr, 8'h00, v);
   endtask

   task automatic do_reset;
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
   endtask

   // one full pwm cycle, counted in clock samples
   task automatic measure(output int hi, output int lo);
      int k;
      k = 0;
      hi = 0;
      lo = 0;
      while (clock_out_pin !== 1'b0 && k < 900) begin @(posedge clk); k++; end
      while (clock_out_pin !== 1'b1 && k < 900) begin @(posedge clk); k++; end
      while (clock_out_pin === 1'b1 && k < 900) begin @(posedge clk); k++; hi++; end
      while (clock_out_pin === 1'b0 && k < 900) begin @(posedge clk); k++; lo++; end
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_reset;
      logic [7:0] offs [8];
      logic [31:0] v;
      offs = '{pwm_clk_pkg::OFF_TIMER_CONTROL, pwm_clk_pkg::OFF_PERIOD_LIMIT,
         pwm_clk_pkg::OFF_TICK_COUNT, pwm_clk_pkg::OFF_SYNC_MODE, pwm_clk_pkg::OFF_DUTY_STAGING,
         pwm_clk_pkg::OFF_PHASE_STAGING, pwm_clk_pkg::OFF_STATUS, 8'h1c};
      do_reset();
      foreach (offs[i]) begin
         rd(offs[i], v);
         check(v, (i == 1) ? 32'hff : 32'h0);
      end
      check({31'h0, sync_oe_n}, 32'h1);
      $display("reset values done");
   endtask

   task automatic t_divide;
      int divs [4];
      int hi;
      int lo;
      divs = '{1, 4, 8, 16};
      do_reset();
      wr(pwm_clk_pkg::OFF_PERIOD_LIMIT, 8'h04);
      wr(pwm_clk_pkg::OFF_DUTY_STAGING, 8'h01);
      foreach (divs[i]) begin
         wr(pwm_clk_pkg::OFF_TIMER_CONTROL, 8'h04 | 8'(i));
         measure(hi, lo);
         check(32'(hi), 32'(divs[i]));
         check(32'(lo), 32'(4 * divs[i]));
      end
      $display("divider and period done");
   endtask

   task automatic t_zero_duty;
      int n;
      n = 0;
      do_reset();
      wr(pwm_clk_pkg::OFF_PERIOD_LIMIT, 8'h03);
      wr(pwm_clk_pkg::OFF_TIMER_CONTROL, 8'h04);
      repeat (40) begin
         @(posedge clk);
         if (clock_out_pin !== 1'b0) n++;
      end
      check(32'(n), 32'h0);
      $display("zero duty done");
   endtask

   task automatic t_staging;
      logic [31:0] v;
      do_reset();
      wr(pwm_clk_pkg::OFF_PERIOD_LIMIT, 8'h09);
      wr(pwm_clk_pkg::OFF_DUTY_STAGING, 8'h03);
      wr(pwm_clk_pkg::OFF_TIMER_CONTROL, 8'h04);
      rd(pwm_clk_pkg::OFF_STATUS, v);
      check(v & 32'hffff, 32'h0);
      repeat (20) @(posedge clk);
      rd(pwm_clk_pkg::OFF_STATUS, v);
      check(v & 32'hff01, 32'h0301);
      wr(pwm_clk_pkg::OFF_TIMER_CONTROL, 8'h00);
      wr(pwm_clk_pkg::OFF_STATUS, 8'h01);
      rd(pwm_clk_pkg::OFF_STATUS, v);
      check(v & 32'h1, 32'h0);
      $display("duty staging done");
   endtask

   task automatic t_run_bit;
      logic [31:0] a;
      logic [31:0] b;
      do_reset();
      wr(pwm_clk_pkg::OFF_TIMER_CONTROL, 8'h04);
      repeat (20) @(posedge clk);
      wr(pwm_clk_pkg::OFF_TIMER_CONTROL, 8'h01);
      rd(pwm_clk_pkg::OFF_TICK_COUNT, a);
      check({31'h0, a !== 32'h0}, 32'h1);
      repeat (20) @(posedge clk);
      rd(pwm_clk_pkg::OFF_TICK_COUNT, b);
      check(b, a);
      check({31'h0, clock_out_pin}, 32'h0);
      wr(pwm_clk_pkg::OFF_TIMER_CONTROL, 8'h03);
      rd(pwm_clk_pkg::OFF_TICK_COUNT, b);
      check(b, a);
      wr(pwm_clk_pkg::OFF_TICK_COUNT, 8'h05);
      rd(pwm_clk_pkg::OFF_TICK_COUNT, b);
      check(b, 32'h05);
      $display("run bit done");
   endtask

   task automatic t_sleep;
      int n;
      int hi;
      int lo;
      logic lvl;
      n = 0;
      do_reset();
      wr(pwm_clk_pkg::OFF_PERIOD_LIMIT, 8'h04);
      wr(pwm_clk_pkg::OFF_DUTY_STAGING, 8'h02);
      wr(pwm_clk_pkg::OFF_TIMER_CONTROL, 8'h05);
      repeat (45) @(posedge clk);
      ce <= 1'b0;
      repeat (2) @(posedge clk);
      lvl = clock_out_pin;
      repeat (40) begin
         @(posedge clk);
         if (clock_out_pin !== lvl) n++;
      end
      ce <= 1'b1;
      check(32'(n), 32'h0);
      measure(hi, lo);
      check(32'(hi), 32'd8);
      check(32'(lo), 32'd12);
      $display("sleep done");
   endtask

   task automatic t_main;
      int n;
      n = 0;
      do_reset();
      wr(pwm_clk_pkg::OFF_PERIOD_LIMIT, 8'h03);
      wr(pwm_clk_pkg::OFF_DUTY_STAGING, 8'h02);
      wr(pwm_clk_pkg::OFF_TIMER_CONTROL, 8'h04);
      wr(pwm_clk_pkg::OFF_SYNC_MODE, 8'h80);
      repeat (4) @(posedge clk);
      repeat (30) begin
         @(posedge clk);
         if (sync_oe_n !== 1'b0 || sync_out !== clock_out_pin) n++;
      end
      check(32'(n), 32'h0);
      $display("main mode done");
   endtask

   task automatic t_secondary;
      logic [31:0] v;
      do_reset();
      wr(pwm_clk_pkg::OFF_DUTY_STAGING, 8'h05);
      wr(pwm_clk_pkg::OFF_PHASE_STAGING, 8'h03);
      model_en <= 1'b1;
      repeat (100) @(posedge clk);
      rd(pwm_clk_pkg::OFF_STATUS, v);
      check(v & 32'hffff00, 32'h0);
      wr(pwm_clk_pkg::OFF_SYNC_MODE, 8'hc0);
      wr(pwm_clk_pkg::OFF_TIMER_CONTROL, 8'h04);
      repeat (100) @(posedge clk);
      rd(pwm_clk_pkg::OFF_STATUS, v);
      check(v & 32'hffff00, 32'h030500);
      model_en <= 1'b0;
      $display("secondary mode done");
   endtask

   // ************************************************************
   // verdict
   // ************************************************************
   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      t_reset();
      t_divide();
      t_zero_duty();
      t_staging();
      t_run_bit();
      t_sleep();
      t_main();
      t_secondary();
      give_verdict();
   end

   // whole run needs about a thousand cycles; this allows far more
   initial begin
      #200000;
      miscompares++;
      give_verdict();
   end
endmodule
